// File: rx_state_fifo_status_regs.sv
// Receiver state, queue status and function enable register group
`timescale 1ns/1ps
module rx_state_fifo_status_regs (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       clk_en_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       queue_mode_i,
  input  wire logic       queue_full_i,
  input  wire logic       queue_overflow_i,
  input  wire logic [7:0] queue_count_i,
  input  wire logic [7:0] queue_threshold_i,
  input  wire logic [7:0] signal_strength_level_raw_i,
  input  wire logic [7:0] squelch_threshold_i,
  input  wire logic       power_up_ok_i,
  output logic [7:0]      reg_rdata_o,
  output logic            queue_clear_o,
  output logic            packet_handler_reset_o,
  output logic            sleep_timer_halt_o,
  output logic            manufacturing_test_enable_o,
  output logic            fast_serial_enable_o,
  output logic [2:0]      current_state_o,
  output logic            soft_reset_o
);

  typedef struct packed {
    rsfsr_pkg::rsfsr_state_t state;
    logic [2:0]              state_code;
    logic [1:0]              qsc_resv;
    logic                    halt;
    logic                    test;
    logic                    fast;
    logic [4:0]              cmd;
    logic [7:0]              rdata;
    logic                    qclr;
    logic                    pkt_rst;
    logic                    srst;
  } rsfsr_top_st_t;

  localparam rsfsr_top_st_t ST_RESET = '{
    state:      rsfsr_pkg::ST_POWER_UP,
    state_code: rsfsr_pkg::CODE_POWER_UP,
    qsc_resv:   rsfsr_pkg::QSC_RESV_RESET,
    halt:       rsfsr_pkg::FEN_HALT_RESET,
    test:       rsfsr_pkg::FEN_TEST_RESET,
    fast:       rsfsr_pkg::FEN_FAST_RESET,
    cmd:        rsfsr_pkg::OSC_CMD_RESET,
    rdata:      8'h00,
    qclr:       1'b0,
    pkt_rst:    1'b0,
    srst:       1'b0
  };

  rsfsr_top_st_t st_reg;
  rsfsr_top_st_t st_next;
  logic [3:0]    qflags;
  logic [7:0]    level;
  logic          wr_qsc;
  logic          wr_fen;
  logic          wr_osc;
  logic          wr_srt;
  logic          soft_key;
  logic          active;

  function automatic logic [2:0] rsfsr_code(input rsfsr_pkg::rsfsr_state_t s);
    logic [2:0] c;
    c = rsfsr_pkg::CODE_POWER_UP;
    unique case (s)
      rsfsr_pkg::ST_POWER_UP: c = rsfsr_pkg::CODE_POWER_UP;
      rsfsr_pkg::ST_SLEEP:    c = rsfsr_pkg::CODE_SLEEP;
      rsfsr_pkg::ST_STANDBY:  c = rsfsr_pkg::CODE_STANDBY;
      rsfsr_pkg::ST_TUNING:   c = rsfsr_pkg::CODE_TUNING;
      rsfsr_pkg::ST_RECEIVE:  c = rsfsr_pkg::CODE_RECEIVE;
      rsfsr_pkg::ST_EEPROM:   c = rsfsr_pkg::CODE_EEPROM;
      default:                c = rsfsr_pkg::CODE_POWER_UP;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  rsfsr_queue_flags u_flags (
    .sys_clk_i         (sys_clk_i),
    .reset_n_i         (reset_n_i),
    .clk_en_i          (clk_en_i),
    .queue_mode_i      (queue_mode_i),
    .queue_full_i      (queue_full_i),
    .queue_overflow_i  (queue_overflow_i),
    .queue_count_i     (queue_count_i),
    .queue_threshold_i (queue_threshold_i),
    .flags_o           (qflags)
  );

  rsfsr_signal_strength_level_filter u_signal_strength_level (
    .sys_clk_i           (sys_clk_i),
    .reset_n_i           (reset_n_i),
    .clk_en_i            (clk_en_i),
    .track_i             (st_reg.state == rsfsr_pkg::ST_RECEIVE),
    .signal_strength_level_raw_i          (signal_strength_level_raw_i),
    .squelch_threshold_i (squelch_threshold_i),
    .level_o             (level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign wr_qsc   = reg_wr_i && (reg_addr_i == rsfsr_pkg::QSC_ADDR);
  assign wr_fen   = reg_wr_i && (reg_addr_i == rsfsr_pkg::FEN_ADDR);
  assign wr_osc   = reg_wr_i && (reg_addr_i == rsfsr_pkg::OSC_ADDR);
  assign wr_srt   = reg_wr_i && (reg_addr_i == rsfsr_pkg::SRT_ADDR);
  assign soft_key = wr_srt && (reg_wdata_i == rsfsr_pkg::SOFT_RESET_KEY);
  assign active   = (st_reg.state == rsfsr_pkg::ST_STANDBY) || (st_reg.state == rsfsr_pkg::ST_TUNING) ||
                    (st_reg.state == rsfsr_pkg::ST_RECEIVE) || (st_reg.state == rsfsr_pkg::ST_EEPROM);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next         = st_reg;
    st_next.srst    = 1'b0;
    st_next.qclr    = 1'b0;
    st_next.pkt_rst = 1'b0;

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        rsfsr_pkg::QSC_ADDR: st_next.rdata = {1'b0, qflags, 1'b0, st_reg.qsc_resv};
        rsfsr_pkg::SSL_ADDR: st_next.rdata = level;
        rsfsr_pkg::FEN_ADDR: st_next.rdata = {1'b0, st_reg.halt, st_reg.test, 2'b00, st_reg.fast, 2'b00};
        rsfsr_pkg::OSC_ADDR: st_next.rdata = {st_reg.state_code, st_reg.cmd};
        default:             st_next.rdata = 8'h00;
      endcase
    end

    if (wr_qsc) begin
      // Reserved bits kept as written; host is expected to keep them zero
      st_next.qsc_resv = reg_wdata_i[rsfsr_pkg::QSC_RESV_MSB:0];
      st_next.qclr     = reg_wdata_i[rsfsr_pkg::QSC_CLR_BIT] && active;
    end

    if (wr_fen) begin
      st_next.halt = reg_wdata_i[rsfsr_pkg::FEN_HALT_BIT];
      st_next.test = reg_wdata_i[rsfsr_pkg::FEN_TEST_BIT];
      st_next.fast = reg_wdata_i[rsfsr_pkg::FEN_FAST_BIT];
    end

    unique case (st_reg.state)
      rsfsr_pkg::ST_POWER_UP: begin
        // Stays here while the power-up sequence reports failure
        if (power_up_ok_i) begin
          st_next.state = rsfsr_pkg::ST_SLEEP;
        end
      end
      default: begin
        // Commands only name working states, never power-up
        if (wr_osc) begin
          st_next.cmd = reg_wdata_i[rsfsr_pkg::OSC_CMD_MSB:0];
          unique case (reg_wdata_i[rsfsr_pkg::OSC_CMD_MSB:0])
            rsfsr_pkg::CMD_EEPROM:  st_next.state = rsfsr_pkg::ST_EEPROM;
            rsfsr_pkg::CMD_STANDBY: st_next.state = rsfsr_pkg::ST_STANDBY;
            rsfsr_pkg::CMD_TUNING:  st_next.state = rsfsr_pkg::ST_TUNING;
            rsfsr_pkg::CMD_RECEIVE: st_next.state = rsfsr_pkg::ST_RECEIVE;
            rsfsr_pkg::CMD_SLEEP:   st_next.state = rsfsr_pkg::ST_SLEEP;
            default:                st_next.state = st_reg.state;
          endcase
        end
      end
    endcase

    if (st_reg.state == rsfsr_pkg::ST_SLEEP) begin
      st_next.qclr    = 1'b1;
      st_next.pkt_rst = 1'b1;
    end

    // Soft reset overrides everything else in the same cycle
    if (soft_key) begin
      st_next       = ST_RESET;
      st_next.srst  = 1'b1;
    end

    st_next.state_code = rsfsr_code(st_next.state);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_reg <= ST_RESET;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o                 = st_reg.rdata;
  assign queue_clear_o               = st_reg.qclr;
  assign packet_handler_reset_o      = st_reg.pkt_rst;
  assign sleep_timer_halt_o          = st_reg.halt;
  assign manufacturing_test_enable_o = st_reg.test;
  assign fast_serial_enable_o        = st_reg.fast;
  assign current_state_o             = st_reg.state_code;
  assign soft_reset_o                = st_reg.srst;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_full_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && queue_mode_i && queue_full_i |=> qflags[3];
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag not set");

  property p_nempty_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && queue_mode_i |=> qflags[2] == ($past(queue_count_i) != 8'h00);
  endproperty
  a_nempty_flag: assert property (p_nempty_flag) else $error("not-empty flag wrong");

  property p_thr_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && queue_mode_i && (queue_count_i < queue_threshold_i) |=> !qflags[1];
  endproperty
  a_thr_flag: assert property (p_thr_flag) else $error("threshold flag set below threshold");

  property p_ovf_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && (!queue_mode_i || !queue_overflow_i) |=> !qflags[0];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag without overflow");

  property p_clear;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && wr_qsc && reg_wdata_i[rsfsr_pkg::QSC_CLR_BIT] && active && !soft_key |=> queue_clear_o;
  endproperty
  a_clear: assert property (p_clear) else $error("queue clear strobe missing");

  property p_sleep_clear;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && (current_state_o == rsfsr_pkg::CODE_SLEEP) && !soft_key |=> queue_clear_o && packet_handler_reset_o;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("sleep did not clear queue");

  property p_squelch;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && (signal_strength_level_raw_i < squelch_threshold_i) |=> level == 8'h00;
  endproperty
  a_squelch: assert property (p_squelch) else $error("level not masked by squelch");

  property p_halt;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && wr_fen && !soft_key |=> sleep_timer_halt_o == $past(reg_wdata_i[rsfsr_pkg::FEN_HALT_BIT]);
  endproperty
  a_halt: assert property (p_halt) else $error("halt bit not taken");

  property p_fast;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && wr_fen && !soft_key |=> fast_serial_enable_o == $past(reg_wdata_i[rsfsr_pkg::FEN_FAST_BIT]) &&
                                         manufacturing_test_enable_o == $past(reg_wdata_i[rsfsr_pkg::FEN_TEST_BIT]);
  endproperty
  a_fast: assert property (p_fast) else $error("enable bits not taken");

  property p_state_read;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && reg_rd_i && (reg_addr_i == rsfsr_pkg::OSC_ADDR) && !soft_key
        |=> reg_rdata_o[7:5] == $past(current_state_o);
  endproperty
  a_state_read: assert property (p_state_read) else $error("state readback wrong");

  property p_power_up_exit;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && (current_state_o == rsfsr_pkg::CODE_POWER_UP) && !soft_key
        |=> current_state_o == ($past(power_up_ok_i) ? rsfsr_pkg::CODE_SLEEP : rsfsr_pkg::CODE_POWER_UP);
  endproperty
  a_power_up_exit: assert property (p_power_up_exit) else $error("power-up exit wrong");

  property p_no_power_up;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && (current_state_o != rsfsr_pkg::CODE_POWER_UP) && !soft_key
        |=> current_state_o != rsfsr_pkg::CODE_POWER_UP;
  endproperty
  a_no_power_up: assert property (p_no_power_up) else $error("entered power-up by command");

  property p_rx_cmd;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && wr_osc && (reg_wdata_i[4:0] == rsfsr_pkg::CMD_RECEIVE) && !soft_key &&
      (current_state_o != rsfsr_pkg::CODE_POWER_UP) |=> current_state_o == rsfsr_pkg::CODE_RECEIVE;
  endproperty
  a_rx_cmd: assert property (p_rx_cmd) else $error("receive command ignored");

  property p_bad_cmd;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && wr_osc && !$onehot(reg_wdata_i[4:0]) && !soft_key &&
      (current_state_o != rsfsr_pkg::CODE_POWER_UP) |=> $stable(current_state_o);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("illegal command changed state");

  property p_soft_reset;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && soft_key |=> soft_reset_o && (current_state_o == rsfsr_pkg::CODE_POWER_UP) &&
                               !sleep_timer_halt_o && !fast_serial_enable_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied");

  property p_clear_reads_zero;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i && reg_rd_i && (reg_addr_i == rsfsr_pkg::QSC_ADDR) && !soft_key |=> !reg_rdata_o[2];
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear bit read back");

  c_soft_reset: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) clk_en_i && soft_key);
  c_enter_rx:   cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
                                current_state_o == rsfsr_pkg::CODE_RECEIVE);
  c_full_read:  cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) reg_rdata_o[6]);
  c_clear:      cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) queue_clear_o && active);

endmodule // rx_state_fifo_status_regs

// File: rsfsr_pkg.sv
// Constants, codes and types of the receiver state and queue status register group
//
// Function
// - Full flag follows queue full in queue modes
// - Not-empty flag follows nonzero unread count
// - Threshold flag set while count reaches threshold
// - Overflow flag follows queue overflow condition
// - Clear bit empties queue in active states
// - Sleep state empties queue, resets packet handler
// - Strength register shows filtered level in receive
// - Level below squelch threshold reads as zero
// - Halt bit stops running sleep timer
// - Test enable bit enables manufacturing test
// - Fast serial bit raises serial clock limit
// - State field reports current operating state
// - Power-up settles in sleep, stays on failure
// - No host command enters power-up state
// - One-hot command field switches operating state
// - Other command values leave the state unchanged but are stored in the command field
// - Key value triggers reset like power-on, except the strength filter and the queue flags, which keep their registers
// - After soft reset, power-up then sleep
package rsfsr_pkg;

  // Register addresses
  localparam logic [6:0] QSC_ADDR = 7'h44;
  localparam logic [6:0] SSL_ADDR = 7'h45;
  localparam logic [6:0] FEN_ADDR = 7'h46;
  localparam logic [6:0] OSC_ADDR = 7'h47;
  localparam logic [6:0] SRT_ADDR = 7'h4f;

  // Queue status control fields
  localparam int QSC_FULL_BIT   = 6;
  localparam int QSC_NEMPTY_BIT = 5;
  localparam int QSC_THR_BIT    = 4;
  localparam int QSC_OVF_BIT    = 3;
  localparam int QSC_CLR_BIT    = 2;
  localparam int QSC_RESV_MSB   = 1;
  localparam logic [1:0] QSC_RESV_RESET = 2'h0;

  // Function enable fields
  localparam int FEN_HALT_BIT = 6;
  localparam int FEN_TEST_BIT = 5;
  localparam int FEN_FAST_BIT = 2;
  localparam logic FEN_HALT_RESET = 1'h0;
  localparam logic FEN_TEST_RESET = 1'h0;
  localparam logic FEN_FAST_RESET = 1'h0;

  // Operating state control fields
  localparam int OSC_STATE_LSB = 5;
  localparam int OSC_CMD_MSB   = 4;
  localparam logic [4:0] OSC_CMD_RESET = 5'h00;

  // State codes as read back
  localparam logic [2:0] CODE_POWER_UP = 3'h0;
  localparam logic [2:0] CODE_SLEEP    = 3'h1;
  localparam logic [2:0] CODE_STANDBY  = 3'h2;
  localparam logic [2:0] CODE_TUNING   = 3'h3;
  localparam logic [2:0] CODE_RECEIVE  = 3'h4;
  localparam logic [2:0] CODE_EEPROM   = 3'h5;

  // One-hot state commands
  localparam logic [4:0] CMD_EEPROM  = 5'h01;
  localparam logic [4:0] CMD_STANDBY = 5'h02;
  localparam logic [4:0] CMD_TUNING  = 5'h04;
  localparam logic [4:0] CMD_RECEIVE = 5'h08;
  localparam logic [4:0] CMD_SLEEP   = 5'h10;

  localparam logic [7:0] SOFT_RESET_KEY = 8'hff;

  // Strength filter: new = old + (raw - old) / 2^shift
  localparam int SIGNAL_STRENGTH_LEVEL_FILTER_SHIFT = 2;
  localparam logic [7:0] SIGNAL_STRENGTH_LEVEL_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_POWER_UP,
    ST_SLEEP,
    ST_STANDBY,
    ST_TUNING,
    ST_RECEIVE,
    ST_EEPROM
  } rsfsr_state_t;

endpackage : rsfsr_pkg

// File: rsfsr_queue_flags.sv
// Registered, level-following receive queue status flags
`timescale 1ns/1ps
module rsfsr_queue_flags (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       clk_en_i,
  input  wire logic       queue_mode_i,
  input  wire logic       queue_full_i,
  input  wire logic       queue_overflow_i,
  input  wire logic [7:0] queue_count_i,
  input  wire logic [7:0] queue_threshold_i,
  output logic [3:0]      flags_o
);

  typedef struct packed {
    logic full;
    logic nempty;
    logic thr;
    logic ovf;
  } rsfsr_qflag_t;

  rsfsr_qflag_t st_reg;
  rsfsr_qflag_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Flags are pure levels; outside queue modes they stay low
  always_comb begin
    st_next.full   = queue_mode_i && queue_full_i;
    st_next.nempty = queue_mode_i && (queue_count_i != 8'h00);
    st_next.thr    = queue_mode_i && (queue_count_i >= queue_threshold_i);
    st_next.ovf    = queue_mode_i && queue_overflow_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign flags_o = st_reg;

endmodule // rsfsr_queue_flags

// File: rsfsr_signal_strength_level_filter.sv
// Low-pass filtered signal strength with squelch masking
`timescale 1ns/1ps
module rsfsr_signal_strength_level_filter (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       clk_en_i,
  input  wire logic       track_i,
  input  wire logic [7:0] signal_strength_level_raw_i,
  input  wire logic [7:0] squelch_threshold_i,
  output logic [7:0]      level_o
);

  typedef struct packed {
    logic [9:0] acc;
    logic [7:0] level;
  } rsfsr_signal_strength_level_st_t;

  rsfsr_signal_strength_level_st_t st_reg;
  rsfsr_signal_strength_level_st_t st_next;
  logic [7:0]     filt;

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator keeps fraction bits so small steps are not lost
  assign filt = 8'(st_reg.acc >> rsfsr_pkg::SIGNAL_STRENGTH_LEVEL_FILTER_SHIFT);

  always_comb begin
    st_next = st_reg;
    if (track_i) begin
      st_next.acc = 10'(st_reg.acc + 10'(signal_strength_level_raw_i) - 10'(filt));
    end
    // Mask on the raw level so a weak burst never leaks through the filter
    if (signal_strength_level_raw_i < squelch_threshold_i) begin
      st_next.level = 8'h00;
    end else begin
      st_next.level = 8'(st_next.acc >> rsfsr_pkg::SIGNAL_STRENGTH_LEVEL_FILTER_SHIFT);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.level;

endmodule // rsfsr_signal_strength_level_filter

// File: rsfsr_host.sv
// Host-side model of the parallel register strobe port
`timescale 1ns/1ps
module rsfsr_host #(
  parameter int SRST_WAIT = 16
) (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic [6:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_wdata_o
);
  initial begin
    reg_addr_o  = 7'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  // Strobes rise and fall on falling edges, one cycle wide
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == rsfsr_pkg::QSC_ADDR) v[1:0] = 2'h0;
    if (a == rsfsr_pkg::FEN_ADDR) v = v & 8'h64;
    @(negedge sys_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= v;
    reg_wr_o    <= 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o <= 1'b0;
    // Block has no lock-out, so the settle wait is cut short
    if (a == rsfsr_pkg::SRT_ADDR && v == rsfsr_pkg::SOFT_RESET_KEY) repeat (SRST_WAIT) @(negedge sys_clk_i);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o <= 1'b0;
    d = reg_rdata_i;
  endtask
endmodule // rsfsr_host

// File: tb.sv
// Self-checking bench for the receiver state and queue status registers
`timescale 1ns/1ps
module tb;
  logic       sys_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       queue_mode_i = 1'b0, queue_full_i = 1'b0, queue_overflow_i = 1'b0;
  logic [7:0] queue_count_i = 8'h00, queue_threshold_i = 8'h00;
  logic [7:0] signal_strength_level_raw_i = 8'h00, squelch_threshold_i = 8'h00;
  logic       power_up_ok_i = 1'b0;
  logic       clk_en_i = 1'b1;
  logic [6:0] reg_addr;
  logic       reg_wr, reg_rd;
  logic [7:0] reg_wdata, reg_rdata, rd_data;
  logic       q_clr, ph_rst, halt, test_en, fast_en, srst;
  logic [2:0] cur;
  int         bad_count = 0;
  int         checks = 0;
  int         clr_cnt = 0, srst_cnt = 0, pup_cnt = 0, c0, p0;
  logic [4:0] cmds [5] = '{rsfsr_pkg::CMD_STANDBY, rsfsr_pkg::CMD_TUNING, rsfsr_pkg::CMD_RECEIVE,
                           rsfsr_pkg::CMD_EEPROM, rsfsr_pkg::CMD_SLEEP};
  logic [2:0] codes [5] = '{rsfsr_pkg::CODE_STANDBY, rsfsr_pkg::CODE_TUNING, rsfsr_pkg::CODE_RECEIVE,
                            rsfsr_pkg::CODE_EEPROM, rsfsr_pkg::CODE_SLEEP};
  logic [4:0] junk [4] = '{5'h00, 5'h03, 5'h11, 5'h1f};

  always #20 sys_clk_i = ~sys_clk_i;

  rsfsr_host h (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
                .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata));

  rx_state_fifo_status_regs DUT (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .queue_mode_i(queue_mode_i),
    .queue_full_i(queue_full_i), .queue_overflow_i(queue_overflow_i), .queue_count_i(queue_count_i),
    .queue_threshold_i(queue_threshold_i), .signal_strength_level_raw_i(signal_strength_level_raw_i), .squelch_threshold_i(squelch_threshold_i),
    .power_up_ok_i(power_up_ok_i), .reg_rdata_o(reg_rdata), .queue_clear_o(q_clr),
    .packet_handler_reset_o(ph_rst), .sleep_timer_halt_o(halt), .manufacturing_test_enable_o(test_en),
    .fast_serial_enable_o(fast_en), .current_state_o(cur), .soft_reset_o(srst));

  // Pulse counters let one-cycle outputs be judged after the fact
  always @(posedge sys_clk_i) begin
    if (q_clr === 1'b1) clr_cnt++;
    if (srst === 1'b1) srst_cnt++;
    if (reset_n_i && cur === rsfsr_pkg::CODE_POWER_UP) pup_cnt++;
  end

  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    h.rd(a, rd_data);
    chk($sformatf("reg %h", a), rd_data, exp);
  endtask

  task automatic wait_state(input logic [2:0] code);
    for (int i = 0; i < 20; i++) begin
      if (cur === code) return;
      @(negedge sys_clk_i);
    end
    bad_count++;
    $display("[ERR] state wait expected %h seen %h", code, cur);
    give_verdict();
  endtask

  task automatic qcase(input logic m, f, o, input logic [7:0] n, t, exp);
    @(negedge sys_clk_i);
    queue_mode_i      <= m;
    queue_full_i      <= f;
    queue_overflow_i  <= o;
    queue_count_i     <= n;
    queue_threshold_i <= t;
    repeat (2) @(negedge sys_clk_i);
    rchk(rsfsr_pkg::QSC_ADDR, exp);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge sys_clk_i);
    reset_n_i <= 1'b1;
    // Power-up held back first: state must stay in power-up
    repeat (6) @(negedge sys_clk_i);
    chk("state pup", {5'h00, cur}, 8'h00);
    power_up_ok_i <= 1'b1;
    wait_state(rsfsr_pkg::CODE_SLEEP);
    rchk(rsfsr_pkg::OSC_ADDR, {rsfsr_pkg::CODE_SLEEP, 5'h00});
    chk("sleep clears", {6'h00, q_clr, ph_rst}, 8'h03);
    rchk(rsfsr_pkg::FEN_ADDR, 8'h00);
    rchk(rsfsr_pkg::SRT_ADDR, 8'h00);
    rchk(7'h40, 8'h00);
    p0 = pup_cnt;
    for (int i = 0; i < 5; i++) begin
      h.wr(rsfsr_pkg::OSC_ADDR, {3'h0, cmds[i]});
      chk("state cmd", {5'h00, cur}, {5'h00, codes[i]});
      rchk(rsfsr_pkg::OSC_ADDR, {codes[i], cmds[i]});
    end
    h.wr(rsfsr_pkg::OSC_ADDR, {3'h0, rsfsr_pkg::CMD_STANDBY});
    foreach (junk[i]) begin
      h.wr(rsfsr_pkg::OSC_ADDR, {3'h0, junk[i]});
      rchk(rsfsr_pkg::OSC_ADDR, {rsfsr_pkg::CODE_STANDBY, junk[i]});
    end
    chk("no pup", 8'(pup_cnt - p0), 8'h00);
    qcase(1'b1, 1'b1, 1'b1, 8'h0a, 8'h0a, 8'h78);
    qcase(1'b1, 1'b0, 1'b0, 8'h09, 8'h0a, 8'h20);
    qcase(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 8'h10);
    qcase(1'b1, 1'b0, 1'b1, 8'hff, 8'hc8, 8'h38);
    qcase(1'b0, 1'b1, 1'b1, 8'h0a, 8'h01, 8'h00);
    c0 = clr_cnt;
    h.wr(rsfsr_pkg::QSC_ADDR, 8'h04);
    repeat (3) @(negedge sys_clk_i);
    chk("clear pulse", 8'(clr_cnt - c0), 8'h01);
    rchk(rsfsr_pkg::QSC_ADDR, 8'h00);
    c0 = clr_cnt;
    h.wr(rsfsr_pkg::QSC_ADDR, 8'h00);
    repeat (3) @(negedge sys_clk_i);
    chk("clear zero", 8'(clr_cnt - c0), 8'h00);
    signal_strength_level_raw_i          <= 8'hc8;
    squelch_threshold_i <= 8'h0a;
    h.wr(rsfsr_pkg::OSC_ADDR, {3'h0, rsfsr_pkg::CMD_RECEIVE});
    repeat (80) @(negedge sys_clk_i);
    rchk(rsfsr_pkg::SSL_ADDR, 8'hc8);
    squelch_threshold_i <= 8'hf0;
    repeat (3) @(negedge sys_clk_i);
    rchk(rsfsr_pkg::SSL_ADDR, 8'h00);
    h.wr(rsfsr_pkg::FEN_ADDR, 8'h64);
    chk("enables", {5'h00, halt, test_en, fast_en}, 8'h07);
    rchk(rsfsr_pkg::FEN_ADDR, 8'h64);
    // Enable low must freeze the block: a legal command is not taken
    @(negedge sys_clk_i);
    clk_en_i <= 1'b0;
    h.wr(rsfsr_pkg::OSC_ADDR, {3'h0, rsfsr_pkg::CMD_STANDBY});
    clk_en_i <= 1'b1;
    chk("frozen state", {5'h00, cur}, {5'h00, rsfsr_pkg::CODE_RECEIVE});
    c0 = srst_cnt;
    p0 = pup_cnt;
    h.wr(rsfsr_pkg::SRT_ADDR, 8'h7f);
    repeat (2) @(negedge sys_clk_i);
    chk("srst ignored", 8'(srst_cnt - c0), 8'h00);
    chk("state kept", {5'h00, cur}, {5'h00, rsfsr_pkg::CODE_RECEIVE});
    h.wr(rsfsr_pkg::SRT_ADDR, 8'hff);
    chk("srst pulse", 8'(srst_cnt - c0), 8'h01);
    chk("pup passed", 8'(pup_cnt > p0), 8'h01);
    wait_state(rsfsr_pkg::CODE_SLEEP);
    rchk(rsfsr_pkg::FEN_ADDR, 8'h00);
    give_verdict();
  end
endmodule // tb
